// ### adcpb_map.svh
`ifndef ADCPB_MAP_SVH
`define ADCPB_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADCPB_OFS_CTRL        4'h0
`define ADCPB_OFS_STATUS      4'h4
`define ADCPB_OFS_LAST        4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCPB_CTRL_ACCEPT     0
`define ADCPB_CTRL_RESTART    1
`define ADCPB_ST_PHASE        0
`define ADCPB_ST_SERIAL       1
`define ADCPB_ST_OS_LO        2
`define ADCPB_ST_UNDERFLOW    5
`define ADCPB_ST_AVAIL        6

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define ADCPB_RESULT_W        18
`define ADCPB_BUS_W           16
`define ADCPB_BUF_DEPTH       2
`define ADCPB_RST_ACCEPT      1'b1
`define ADCPB_RST_WORD        18'h0_0000
`define ADCPB_RST_BUS         16'h0000

`endif

// ### adcpb_pkg.sv
package adcpb_pkg;

  typedef logic [17:0] adcpb_word_t;

  typedef enum logic [0:0] {
    PH_UPPER,
    PH_LOWER
  } adcpb_phase_t;

  typedef struct packed {
    logic         cs_n_q;
    logic         rd_n_q;
    logic         strobe_q;
    adcpb_phase_t phase;
    adcpb_word_t  held;
    logic [15:0]  bus;
    logic [15:0]  bus_oe;
    adcpb_word_t  sh_a;
    adcpb_word_t  sh_b;
    logic         load_b;
    logic         underflow;
    logic         accept;
    logic         waitreq;
    logic [31:0]  rdata;
    logic [2:0]   os_sel;
    logic         iface_ser;
  } adcpb_state_t;

  typedef struct packed {
    adcpb_word_t [1:0] mem;
    logic [1:0]        count;
    logic              in_ready;
  } adcpb_buf_state_t;

endpackage

// ### adcpb_stream_if.sv
interface adcpb_stream_if;
  import adcpb_pkg::*;
  adcpb_word_t data;
  logic        valid;
  logic        ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ### adcpb_buffer.sv
`include "adcpb_map.svh"

module adcpb_buffer
  import adcpb_pkg::*;
#(
  parameter int DEPTH = `ADCPB_BUF_DEPTH
) (
  input  wire logic   i_sys_clk,  // System clock
  input  wire logic   i_reset,    // Asynchronous reset, active high
  adcpb_stream_if.snk fill,       // Words arriving
  adcpb_stream_if.src drain       // Words leaving
);

  generate
    if (DEPTH != 2) begin : g_bad_depth
      $error("adcpb_buffer supports a depth of two only");
    end
  endgenerate

  adcpb_buf_state_t s;
  adcpb_buf_state_t next_s;
  logic             push;
  logic             pop;

  assign fill.ready  = s.in_ready;
  assign drain.valid = (s.count != 2'd0);
  assign drain.data  = s.mem[0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    push   = fill.valid && s.in_ready;
    pop    = drain.valid && drain.ready;
    if (pop) begin
      next_s.mem[0] = s.mem[1];
    end
    if (push) begin
      // Slot the new word after whatever survives the pop
      if (s.count - 2'(pop) == 2'd0) begin
        next_s.mem[0] = fill.data;
      end else begin
        next_s.mem[1] = fill.data;
      end
    end
    next_s.count    = s.count + 2'(push) - 2'(pop);
    // Ready from a flop keeps the source free of a combinational path
    next_s.in_ready = (next_s.count != 2'd2);
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '{mem: '0, count: 2'd0, in_ready: 1'b1};
    end else begin
      s <= next_s;
    end
  end

endmodule // adcpb_buffer

// ### adcpb_result_port.sv
// Overview of operation
// RQ1: Oversampling select read as three bits, input 2 most significant.
// RQ2: Parallel mode drives bus only while chip select and read both low; the registered enables here trail both edges by one clock.
// RQ3: Line 15 gives bit 17 first strobe, bit 1 second strobe.
// RQ4: Line 14 gives bit 16 first strobe, bit 0 second strobe.
// RQ5: Lines 13..9 give bits 15..11 first, zero second strobe.
// RQ6: Lines 6..0 give bits 8..2 first, zero second strobe.
// RQ7: Line 7 gives bit 9 in parallel, serial output A in serial.
// RQ8: Line 8 gives bit 10 in parallel, serial output B in serial.
// RQ9: In serial mode the system grounds the unused bus lines.
// RQ10: Results are carried as two's complement, sign in bit 17.
// RQ11: Two strobes per result: upper part first, low two bits second.
// RQ12: Interface select low picks parallel, high picks serial.
// RQ13: Lines 7 and 8 drive zero on the second strobe.
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`include "adcpb_map.svh"

module adcpb_result_port
  import adcpb_pkg::*;
#(
  parameter int RESULT_W = `ADCPB_RESULT_W,
  parameter int BUS_W    = `ADCPB_BUS_W
) (
  input  wire logic        i_sys_clk,            // System clock, 100 MHz
  input  wire logic        i_reset,              // Async reset, active high
  input  wire logic [3:0]  i_avs_address,        // Byte address
  input  wire logic        i_avs_read,           // Read request
  input  wire logic        i_avs_write,          // Write request
  input  wire logic [31:0] i_avs_writedata,      // Write data
  input  wire logic [3:0]  i_avs_byteenable,     // Byte lanes
  output logic      [31:0] o_avs_readdata,       // Read data
  output logic             o_avs_waitrequest,    // Stall, high = wait
  input  wire logic [17:0] i_result_data,        // Conversion result
  input  wire logic        i_result_valid,       // Result offered
  output logic             o_result_ready,       // Result accepted
  input  wire logic        i_cs_n,               // Chip select, low
  input  wire logic        i_rd_n,               // Read strobe / sclk
  input  wire logic        i_interface_select,   // 0 parallel, 1 serial
  input  wire logic [2:0]  i_oversample_ratio_sel, // Ratio select
  output logic      [15:0] o_result_bus,         // Bus line values
  output logic      [15:0] o_result_bus_oe       // Bus drive enables
);

  generate
    if (RESULT_W != 18 || BUS_W != 16) begin : g_bad_width
      $error("adcpb_result_port serves 18-bit results on 16 lines only");
    end
    // The package word type must be as wide as the result it carries
    if ($bits(adcpb_word_t) != RESULT_W) begin : g_bad_word
      $error("adcpb_result_port word type does not match RESULT_W");
    end
    // Registers are decoded by whole offset, so each needs its own
    if (`ADCPB_OFS_CTRL == `ADCPB_OFS_STATUS
        || `ADCPB_OFS_STATUS == `ADCPB_OFS_LAST
        || `ADCPB_OFS_CTRL == `ADCPB_OFS_LAST) begin : g_bad_map
      $error("adcpb_result_port needs three distinct register offsets");
    end
    // Status fields share one word and must not land on each other
    if (`ADCPB_ST_PHASE >= `ADCPB_ST_SERIAL
        || `ADCPB_ST_SERIAL >= `ADCPB_ST_OS_LO
        || `ADCPB_ST_OS_LO + 3 > `ADCPB_ST_UNDERFLOW
        || `ADCPB_ST_UNDERFLOW >= `ADCPB_ST_AVAIL) begin : g_bad_status
      $error("adcpb_result_port status fields overlap");
    end
    if (`ADCPB_CTRL_ACCEPT == `ADCPB_CTRL_RESTART) begin : g_bad_ctrl
      $error("adcpb_result_port control bits overlap");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Upper strobe pattern: lines 15..0 carry result bits 17..2
  function automatic logic [15:0] upper_lines(input adcpb_word_t w);
    upper_lines = w[17:2]; // RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
  endfunction

  // Lower strobe pattern: bits 1 and 0 on top, every other line low
  function automatic logic [15:0] lower_lines(input adcpb_word_t w);
    lower_lines = {w[1], w[0], 14'h0000}; // RQ3 RQ4 RQ5 RQ6 RQ13
  endfunction

  // Sign extension keeps a negative result negative when read as a word
  function automatic logic [31:0] sign_ext(input adcpb_word_t w);
    sign_ext = {{14{w[17]}}, w}; // RQ10
  endfunction

  // ----------------------------------------------------------------------
  // Buffer between the converter and the bus
  // ----------------------------------------------------------------------
  adcpb_stream_if in_if ();
  adcpb_stream_if out_if ();

  logic pop;

  assign in_if.data     = i_result_data;
  assign in_if.valid    = i_result_valid;
  assign o_result_ready = in_if.ready;
  assign out_if.ready   = pop;

  adcpb_buffer #(
    .DEPTH (`ADCPB_BUF_DEPTH)
  ) u_buffer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .fill      (in_if.snk),
    .drain     (out_if.src)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  adcpb_state_t s;
  adcpb_state_t next_s;

  logic        serial_mode;
  logic        strobe_now;
  logic        strobe_start;
  logic        cs_fall;
  logic        sclk_rise;
  logic        take;
  logic        bus_req;
  logic        bus_write;
  logic        restart;
  logic        clear_underflow;
  logic [31:0] status_word;

  assign o_result_bus      = s.bus;
  assign o_result_bus_oe   = s.bus_oe;
  assign o_avs_readdata    = s.rdata;
  assign o_avs_waitrequest = s.waitreq;

  always_comb begin
    next_s = s;
    pop    = 1'b0;

    // --------------------------------------------------------------------
    // Pin sampling and edge detection
    // --------------------------------------------------------------------
    // Pins are synchronous to the clock, so no synchroniser delays them;
    // edges are found against last cycle's copy kept in the state
    serial_mode     = i_interface_select; // RQ12
    strobe_now      = !serial_mode && !i_cs_n && !i_rd_n;
    strobe_start    = strobe_now && !s.strobe_q;
    cs_fall         = serial_mode && !i_cs_n && s.cs_n_q;
    sclk_rise       = serial_mode && !i_cs_n && i_rd_n && !s.rd_n_q;
    take            = out_if.valid && s.accept;
    next_s.cs_n_q   = i_cs_n;
    next_s.rd_n_q   = i_rd_n;
    next_s.strobe_q = strobe_now;
    next_s.os_sel   = {i_oversample_ratio_sel[2],
                       i_oversample_ratio_sel[1],
                       i_oversample_ratio_sel[0]}; // RQ1
    next_s.iface_ser = serial_mode;

    // --------------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------------
    bus_req         = (i_avs_read || i_avs_write) && s.waitreq;
    bus_write       = i_avs_write && !s.waitreq;
    restart         = 1'b0;
    clear_underflow = 1'b0;
    status_word     = 32'h0000_0000;
    status_word[`ADCPB_ST_PHASE]     = (s.phase == PH_LOWER);
    status_word[`ADCPB_ST_SERIAL]    = s.iface_ser;
    status_word[`ADCPB_ST_OS_LO +: 3] = s.os_sel;
    status_word[`ADCPB_ST_UNDERFLOW] = s.underflow;
    status_word[`ADCPB_ST_AVAIL]     = out_if.valid;

    // One wait cycle: data is loaded while waitrequest drops
    next_s.waitreq = !bus_req;
    if (bus_req && i_avs_read) begin
      case (i_avs_address)
        `ADCPB_OFS_CTRL: begin
          next_s.rdata = {31'h0000_0000, s.accept};
        end
        `ADCPB_OFS_STATUS: begin
          next_s.rdata = status_word;
        end
        `ADCPB_OFS_LAST: begin
          next_s.rdata = sign_ext(s.held); // RQ10
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (bus_write && i_avs_byteenable[0]) begin
      case (i_avs_address)
        `ADCPB_OFS_CTRL: begin
          next_s.accept = i_avs_writedata[`ADCPB_CTRL_ACCEPT];
          restart       = i_avs_writedata[`ADCPB_CTRL_RESTART];
        end
        `ADCPB_OFS_STATUS: begin
          clear_underflow = i_avs_writedata[`ADCPB_ST_UNDERFLOW];
        end
        default: begin
          restart = 1'b0;
        end
      endcase
    end
    if (clear_underflow) begin
      next_s.underflow = 1'b0;
    end
    if (restart) begin
      next_s.phase = PH_UPPER;
    end

    // --------------------------------------------------------------------
    // Parallel read strobes
    // --------------------------------------------------------------------
    if (strobe_start) begin
      if (s.phase == PH_UPPER) begin
        // A missing word repeats the last one rather than stalling the host
        if (take) begin
          pop         = 1'b1;
          next_s.held = out_if.data; // RQ10
        end else begin
          next_s.underflow = 1'b1;
        end
        next_s.bus   = upper_lines(next_s.held); // RQ11
        next_s.phase = PH_LOWER;
      end else begin
        next_s.bus   = lower_lines(s.held); // RQ11
        next_s.phase = PH_UPPER;
      end
    end

    // --------------------------------------------------------------------
    // Serial outputs on lines 7 and 8
    // --------------------------------------------------------------------
    // A frame cut short by chip select keeps its shift registers; the next
    // falling chip select reloads both, so no stale bit leaks into it
    next_s.load_b = 1'b0;
    if (cs_fall) begin
      if (take) begin
        pop           = 1'b1;
        next_s.held   = out_if.data;
        next_s.sh_a   = out_if.data;
        next_s.load_b = 1'b1;
      end else begin
        next_s.sh_a      = s.held;
        next_s.sh_b      = `ADCPB_RST_WORD;
        next_s.underflow = 1'b1;
      end
    end else begin
      if (sclk_rise) begin
        next_s.sh_a = {s.sh_a[16:0], 1'b0};
        next_s.sh_b = {s.sh_b[16:0], 1'b0};
      end
      // The second word follows one cycle later; only one pop per cycle
      if (s.load_b) begin
        if (take) begin
          pop         = 1'b1;
          next_s.sh_b = out_if.data;
        end else begin
          next_s.sh_b = `ADCPB_RST_WORD;
        end
      end
    end

    // --------------------------------------------------------------------
    // Drive enables
    // --------------------------------------------------------------------
    if (serial_mode) begin
      // Other lines stay undriven: the board grounds them
      next_s.bus       = `ADCPB_RST_BUS; // RQ9
      next_s.bus[7]    = next_s.sh_a[17]; // RQ7
      next_s.bus[8]    = next_s.sh_b[17]; // RQ8
      next_s.bus_oe    = `ADCPB_RST_BUS;
      next_s.bus_oe[7] = !i_cs_n; // RQ7
      next_s.bus_oe[8] = !i_cs_n; // RQ8
    end else begin
      // Registered enables trail the strobe by a cycle at both ends; the
      // host allows for that before sampling and before reusing the lines
      next_s.bus_oe = {16{strobe_now}}; // RQ2
    end
  end

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '{cs_n_q:    1'b1,
             rd_n_q:    1'b1,
             strobe_q:  1'b0,
             phase:     PH_UPPER,
             held:      `ADCPB_RST_WORD,
             bus:       `ADCPB_RST_BUS,
             bus_oe:    `ADCPB_RST_BUS,
             sh_a:      `ADCPB_RST_WORD,
             sh_b:      `ADCPB_RST_WORD,
             load_b:    1'b0,
             underflow: 1'b0,
             accept:    `ADCPB_RST_ACCEPT,
             waitreq:   1'b1,
             rdata:     32'h0000_0000,
             os_sel:    3'h0,
             iface_ser: 1'b0};
    end else begin
      s <= next_s;
    end
  end

endmodule // adcpb_result_port

// ### adcpb_result_port_chk.sv
module adcpb_result_port_chk (
  input wire logic        i_sys_clk,              // Clock
  input wire logic        i_reset,                // Reset
  input wire logic [3:0]  i_avs_address,          // Address
  input wire logic        i_avs_read,             // Read
  input wire logic        i_avs_write,            // Write
  input wire logic [31:0] i_avs_writedata,        // Write data
  input wire logic [3:0]  i_avs_byteenable,       // Lanes
  input wire logic [31:0] o_avs_readdata,         // Read data
  input wire logic        o_avs_waitrequest,      // Wait
  input wire logic [17:0] i_result_data,          // Result
  input wire logic        i_result_valid,         // Offered
  input wire logic        o_result_ready,         // Room
  input wire logic        i_cs_n,                 // Select
  input wire logic        i_rd_n,                 // Strobe
  input wire logic        i_interface_select,     // Mode
  input wire logic [2:0]  i_oversample_ratio_sel, // Ratio
  input wire logic [15:0] o_result_bus,           // Lines
  input wire logic [15:0] o_result_bus_oe         // Enables
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic strobe_d;
    logic phase;
  } adcpb_chk_t;
  adcpb_chk_t st;
  adcpb_chk_t next_st;
  logic       start;
  logic       rd_take;
  assign start = !i_interface_select && !i_cs_n && !i_rd_n && !st.strobe_d;
  assign rd_take = i_avs_read && o_avs_waitrequest;
  // A restart write pulls the expected phase back to upper; a strobe
  // starting in the same cycle still wins, as in the port itself
  always_comb begin
    next_st = st;
    next_st.strobe_d = !i_cs_n && !i_rd_n;
    if (i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0
        && i_avs_byteenable[0] && i_avs_writedata[1])
      next_st.phase = 1'b0;
    if (start)
      next_st.phase = !st.phase;
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset)
      st <= '0;
    else
      st <= next_st;
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_bus_release: assert property (
    |o_result_bus_oe |-> !$past(i_cs_n)
      && ($past(i_interface_select) || !$past(i_rd_n)))
    else $error("bus driven without a strobe");
  a_bus_drive: assert property (
    !i_interface_select && !i_cs_n && !i_rd_n
      |=> o_result_bus_oe == 16'hFFFF)
    else $error("bus not driven during strobe");
  a_lower_zero: assert property (
    start && st.phase |=> o_result_bus[13:0] == 14'h0000)
    else $error("lower strobe lines not zero");
  a_par_hold: assert property (
    !i_interface_select && !start |=> $stable(o_result_bus))
    else $error("bus changed without a strobe");
  a_serial_idle: assert property (
    i_interface_select |=> (o_result_bus_oe & 16'hFE7F) == 16'h0000)
    else $error("unused line driven in serial mode");
  a_serial_oe: assert property (
    i_interface_select |=> o_result_bus_oe[8:7] == {2{!$past(i_cs_n)}})
    else $error("serial outputs enable wrong");
  a_wait_once: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access not answered after one wait");
  a_ack_single: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  a_unmapped_zero: assert property (
    rd_take && !(i_avs_address inside {4'h0, 4'h4, 4'h8})
      |=> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_status_pins: assert property (
    rd_take && i_avs_address == 4'h4 && $stable(i_oversample_ratio_sel)
      && $stable(i_interface_select) |=> o_avs_readdata[4:1]
      == {$past(i_oversample_ratio_sel), $past(i_interface_select)})
    else $error("status pin fields wrong");
  a_last_sign: assert property (
    rd_take && i_avs_address == 4'h8
      |=> o_avs_readdata[31:18] == {14{o_avs_readdata[17]}})
    else $error("last result not sign extended");
  c_upper: cover property (start && !st.phase);
  c_lower: cover property (start && st.phase);
  c_serial: cover property (i_interface_select && $fell(i_cs_n));
  c_full: cover property (!o_result_ready);
endmodule // adcpb_result_port_chk

bind adcpb_result_port adcpb_result_port_chk chk_u (.*);

// ### adcpb_host_model.sv
module adcpb_host_model (
  input  wire logic        i_sys_clk, // Clock
  input  wire logic [15:0] i_bus,     // Bus line values
  input  wire logic [15:0] i_oe,      // Bus drive enables
  output logic             o_cs_n,    // Chip select, low
  output logic             o_rd_n     // Read strobe or serial clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
  end
  // Undriven lines float, so they read as z and never match by luck
  task automatic strobe(output logic [15:0] v, output logic [15:0] e);
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    for (int i = 0; i < 16; i++)
      v[i] = i_oe[i] ? i_bus[i] : 1'bz;
    e = i_oe;
    @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    @(posedge i_sys_clk);
  endtask
  // Other lines are grounded on the board; any enable seen there is kept
  task automatic frame(output logic [17:0] a, output logic [17:0] b,
                       output logic [15:0] u);
    u = 16'h0000;
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    for (int i = 17; i >= 0; i--) begin
      @(negedge i_sys_clk);
      a[i] = i_oe[7] ? i_bus[7] : 1'bz;
      b[i] = i_oe[8] ? i_bus[8] : 1'bz;
      u = u | i_oe;
      @(posedge i_sys_clk);
      o_rd_n <= 1'b0;
      @(posedge i_sys_clk);
      o_rd_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
    end
    o_cs_n <= 1'b1;
  endtask
endmodule // adcpb_host_model

// ### tb_adc_parallel_result_bus.sv
module tb_adc_parallel_result_bus;
  timeunit 1ns;
  timeprecision 1ps;
  import adcpb_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  i_avs_address = 4'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [3:0]  i_avs_byteenable = 4'h1;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  adcpb_word_t i_result_data = '0;
  logic        i_result_valid = 1'b0;
  logic        o_result_ready;
  logic        i_cs_n;
  logic        i_rd_n;
  logic        i_interface_select = 1'b0;
  logic [2:0]  i_oversample_ratio_sel = 3'h0;
  logic [15:0] o_result_bus;
  logic [15:0] o_result_bus_oe;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  adcpb_word_t model[$];
  adcpb_word_t held = '0;
  adcpb_word_t w;
  logic [31:0] rv;
  logic [15:0] bv;
  logic [15:0] ov;
  logic [17:0] sa;
  logic [17:0] sb;

  adcpb_result_port dut_u (.*);
  adcpb_host_model host_u (.i_sys_clk(i_sys_clk), .i_bus(o_result_bus),
    .i_oe(o_result_bus_oe), .o_cs_n(i_cs_n), .o_rd_n(i_rd_n));

  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic avs(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    @(posedge i_sys_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    r = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic status(input logic [6:0] e);
    avs(1'b0, 4'h4, 32'h0000_0000, 4'h1, rv);
    check("status", 32'(rv[6:0]), 32'(e));
  endtask
  task automatic push(input adcpb_word_t d);
    @(posedge i_sys_clk);
    i_result_data <= d;
    i_result_valid <= 1'b1;
    do @(posedge i_sys_clk); while (o_result_ready !== 1'b1);
    i_result_valid <= 1'b0;
    model.push_back(d);
  endtask
  task automatic pair();
    w = model.pop_front();
    held = w;
    host_u.strobe(bv, ov);
    check("upper", 32'(bv), 32'(w[17:2]));
    check("enable", 32'(ov), 32'h0000_FFFF);
    host_u.strobe(bv, ov);
    check("lower", 32'(bv), 32'({w[1:0], 14'h0000}));
    avs(1'b0, 4'h8, 32'h0000_0000, 4'h1, rv);
    check("last", rv, {{14{w[17]}}, w});
  endtask

  initial begin
    rv = $urandom(24972);
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    avs(1'b0, 4'h0, 32'h0000_0000, 4'h1, rv);
    check("ctrl", rv, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      i_oversample_ratio_sel <= 3'(k);
      status(7'(k << 2));
    end
    avs(1'b0, 4'hC, 32'h0000_0000, 4'h1, rv);
    check("unmapped", rv, 32'h0000_0000);
    // Lane 0 carries every writable bit, so other lanes do nothing
    avs(1'b1, 4'h0, 32'h0000_0000, 4'h2, rv);
    avs(1'b1, 4'hC, 32'h0000_0000, 4'h1, rv);
    avs(1'b0, 4'h0, 32'h0000_0000, 4'h1, rv);
    check("ctrl", rv, 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      push(k == 0 ? 18'h1_FFFF : k == 1 ? 18'h2_0000 : 18'($urandom()));
      pair();
    end
    push(18'($urandom()));
    push(18'($urandom()));
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("ready", 32'(o_result_ready), 32'h0000_0000);
    status(7'h5C);
    fork
      push(18'($urandom()));
      begin
        pair();
        pair();
      end
    join
    pair();
    status(7'h1C);
    avs(1'b1, 4'h0, 32'h0000_0000, 4'h1, rv);
    push(18'($urandom()));
    status(7'h5C);
    host_u.strobe(bv, ov);
    check("held", 32'(bv), 32'(held[17:2]));
    status(7'h7D);
    avs(1'b1, 4'h4, 32'h0000_0020, 4'h1, rv);
    avs(1'b1, 4'h0, 32'h0000_0003, 4'h1, rv);
    status(7'h5C);
    pair();
    i_interface_select <= 1'b1;
    push(18'($urandom()));
    push(18'($urandom()));
    status(7'h5E);
    host_u.frame(sa, sb, ov);
    check("serial_a", 32'(sa), 32'(model.pop_front()));
    check("serial_b", 32'(sb), 32'(model.pop_front()));
    check("grounded", 32'(ov & 16'hFE7F), 32'h0000_0000);
    // One word left: line B has nothing to send and stays low
    push(18'($urandom()));
    host_u.frame(sa, sb, ov);
    check("serial_a", 32'(sa), 32'(model.pop_front()));
    check("serial_b", 32'(sb), 32'h0000_0000);
    check("grounded", 32'(ov & 16'hFE7F), 32'h0000_0000);
    repeat (4) @(posedge i_sys_clk);
    i_interface_select <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    finish_test();
  end
endmodule // tb_adc_parallel_result_bus
